// ### tb_top.sv
// Self-checking bench for the suspend wake event logic.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import wake_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0;
    logic rrdy = 1'b0, ext = 1'b0, good = 1'b0, irq = 1'b0, susp = 1'b0, res = 1'b0;
    logic [5:0] fev = 6'h00;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdata;
    logic [PIN_N-1:0] pin = 11'h000;
    logic usb_s, usb_r, wake, sus, awr, wr, bv, arr, rv;
    logic [1:0] rresp;
    logic [33:0] rd_q[$];
    logic [1:0] wk_q[$];
    logic [1:0] wr_q[$];
    logic [1:0] qt_q[$];
    logic [1:0] bresp;
    logic quiet;
    logic sus_d = 1'b0;
    int failures = 0, total_checks = 0, p;
    always #4 clk = ~clk;
    wake_event_logic u_wake_event_logic (
        .CLK_I(clk), .RST_B_I(rst_n), .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(awa),
        .AWPROT_I(3'h0), .WVALID_I(wv), .WREADY_O(wr), .WDATA_I(wd), .WSTRB_I(4'hF),
        .BVALID_O(bv), .BREADY_I(brdy), .BRESP_O(bresp), .ARVALID_I(arv), .ARREADY_O(arr),
        .ARADDR_I(ara), .ARPROT_I(3'h0), .RVALID_O(rv), .RREADY_I(rrdy), .RDATA_O(rdata),
        .RRESP_O(rresp), .PIN_I(pin), .EXT_PHY_MODE_I(ext), .UNICAST_EV_I(fev[0]),
        .MAGIC_EV_I(fev[1]), .PATTERN_EV_I(fev[2]), .PERFECT_DA_EV_I(fev[3]),
        .BROADCAST_EV_I(fev[4]), .GOOD_FRAME_I(good), .PHY_IRQ_I(irq), .LINK_UP_I(fev[5]),
        .USB_SUSPEND_I(usb_s), .USB_RESUME_I(usb_r), .REMOTE_WAKE_O(wake),
        .SUSPENDED_O(sus), .PHY_QUIET_O(quiet));
    usb_host_model u_usb_host_model (.clk_i(clk), .susp_req_i(susp), .res_req_i(res),
        .usb_suspend_o(usb_s), .usb_resume_o(usb_r));
    task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
        total_checks++;
        if (e !== g) begin
            failures++;
            $display("wrong value at %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic cmp_wk(input logic [1:0] e, input logic [1:0] g);
        cmp_rd({32'h0, e}, {32'h0, g});
    endtask
    task automatic cmp_rs(input logic [1:0] e, input logic [1:0] g);
        cmp_rd({32'h0, e}, {32'h0, g});
    endtask
    task automatic cmp_qt(input logic [1:0] e, input logic [1:0] g);
        cmp_rd({32'h0, e}, {32'h0, g});
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic tmo;
        failures++;
        close_out();
    endtask
    // One bus cycle; each channel is released only at the edge that takes it.
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        if (w) wr_q.push_back((a > IRQ_STATUS_ADDR) ? RESP_SLVERR : RESP_OKAY);
        @(posedge clk);
        {awv, wv, brdy} <= {3{w}};
        {arv, rrdy} <= {2{~w}};
        awa <= a;
        ara <= a;
        wd <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            if (arr) arv <= 1'b0;
            if (bv || rv) break;
        end
        {brdy, rrdy} <= 2'b00;
        if (n == 50) tmo();
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rd_q.push_back(e);
        axi(1'b0, a, 32'h0);
    endtask
    // Suspends the device; without an expected wake the host resumes it itself.
    task automatic sleep(input logic exp, input logic q);
        int n;
        qt_q.push_back({1'b1, q});
        if (exp) wk_q.push_back(2'b10);
        @(posedge clk);
        susp <= 1'b1;
        @(posedge clk);
        susp <= 1'b0;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (wake) break;
        end
        if (n == 40 && exp) tmo();
        if (!exp) res <= 1'b1;
        @(posedge clk);
        res <= 1'b0;
    endtask
    always @(posedge clk) begin
        sus_d <= sus;
        if (rv && rrdy) begin
            cmp_rd(rd_q.size() ? rd_q.pop_front() : 34'h0, {rresp, rdata});
        end
        if (bv && brdy) begin
            cmp_rs(wr_q.size() ? wr_q.pop_front() : 2'h3, bresp);
        end
        if (wake) begin
            cmp_wk(wk_q.size() ? wk_q.pop_front() : 2'h0, {wake, sus});
        end
        if (sus && !sus_d) begin
            cmp_qt(qt_q.size() ? qt_q.pop_front() : 2'h0, {sus, quiet});
        end
    end
    initial begin
        p = $urandom(32'h8348);
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(PWR_CTL_ADDR, {RESP_OKAY, 32'h0000_0002});
        rd(8'h18, {RESP_SLVERR, 32'h0000_0000});
        axi(1'b1, 8'h18, 32'h0000_0003);
        irq <= 1'b1;
        axi(1'b1, PWR_CTL_ADDR, 32'h0000_0008);
        sleep(1'b0, 1'b0);
        axi(1'b1, PWR_CTL_ADDR, 32'h0000_0019);
        rd(PWR_CTL_ADDR, {RESP_OKAY, 32'h0000_0019});
        sleep(1'b1, 1'b1);
        irq <= 1'b0;
        axi(1'b1, FRAME_WAKE_ADDR, 32'h0000_0002);
        axi(1'b1, PWR_CTL_ADDR, 32'h0000_0034);
        fev[1] <= 1'b1;
        @(posedge clk);
        fev[1] <= 1'b0;
        sleep(1'b1, 1'b0);
        rd(FRAME_WAKE_ADDR, {RESP_OKAY, 32'h0000_0102});
        axi(1'b1, FRAME_WAKE_ADDR, 32'h0000_0F00);
        axi(1'b1, PWR_CTL_ADDR, 32'h0000_0033);
        good <= 1'b1;
        @(posedge clk);
        good <= 1'b0;
        sleep(1'b1, 1'b0);
        rd(PWR_CTL_ADDR, {RESP_OKAY, 32'h0000_0023});
        axi(1'b1, PIN_CFG_ADDR, 32'h0000_007F);
        axi(1'b1, PIN_WAKE_ADDR, 32'h8080_0080);
        axi(1'b1, PWR_CTL_ADDR, 32'h0000_0023);
        fev[5] <= 1'b1;
        sleep(1'b1, 1'b0);
        fev[5] <= 1'b0;
        rd(IRQ_STATUS_ADDR, {RESP_OKAY, 32'h0000_0080});
        axi(1'b1, IRQ_STATUS_ADDR, 32'h0000_0080);
        axi(1'b1, PWR_CTL_ADDR, 32'h0000_0022);
        ext <= 1'b1;
        axi(1'b1, PIN_CFG_ADDR, 32'h0000_00F7);
        axi(1'b1, PIN_WAKE_ADDR, 32'h0008_0008);
        pin[3] <= 1'b1;
        sleep(1'b0, 1'b0);
        p = 8 + $urandom % 3;
        axi(1'b1, PIN_WAKE_ADDR, (32'h1 << p) | (32'h1 << (p + 16)));
        pin[p] <= 1'b1;
        sleep(1'b1, 1'b0);
        rd(IRQ_STATUS_ADDR, {RESP_OKAY, 32'h1 << p});
        close_out();
    end
endmodule

`default_nettype wire

// ### usb_host_model.sv
// Behavioural USB host that signals suspend and resume to the device.
`timescale 1ns/1ps
`default_nettype none

module usb_host_model (
    input wire logic clk_i,
    input wire logic susp_req_i,
    input wire logic res_req_i,
    output logic usb_suspend_o,
    output logic usb_resume_o
);
    // Suspend follows driver.
    // Bus signalling reaches the device one cycle after the driver asks for it.
    always_ff @(posedge clk_i) begin
        usb_suspend_o <= susp_req_i;
        usb_resume_o <= res_req_i;
    end
endmodule

`default_nettype wire

// ### wake_event_logic.sv
// Suspend wake event detection and remote wake generation with AXI4-Lite registers.
// How it works
// - Pins 0 to 7 wake only with the internal PHY, never in external mode.
// - Pins 8 to 10 wake in both internal and external PHY modes.
// - Five frame enables gate their events into one composite frame wake signal.
// - Internal wake from frame enable plus composite, or energy enable plus PHY interrupt.
// - Status bit 1 marks frame wake, status bit 0 marks energy detect.
// - Separate seen bits record pattern, magic, perfect DA and broadcast frames.
// - Frame wake reaches remote wake only in suspend code 00b.
// - Energy detect reaches remote wake only in suspend code 01b.
// - A configured internal wake event asserts the remote wake output.
// - With all frame enables clear, good frames set status bit 1 regardless.
// - Good frame wake reaches remote wake only in suspend code 11b.
// - Any configured pin 0 to 10 wakes in every suspend state.
// - Pins 0 to 7 have an active low wake enable bit each.
// - Pins 8 to 10 qualify when function is 00b and direction is input.
// - Each pin has a wake enable bit and a polarity bit.
// - Link select drives pin 7 wake from link up in codes 00b or 11b.
// - A pin wake returns to normal, pulses remote wake and sets its flag.
// - Status bit 1 refuses clearing while the MAC wake event persists.
// - Status bit 0 refuses clearing while the PHY interrupt persists.
// - In energy detect power down the PHY neither sends nor receives data.
// - Suspend codes 00b to 11b; 10b is default, host or pin wake only.
`timescale 1ns/1ps
`default_nettype none

module wake_event_logic
    import wake_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [ADDR_W-1:0] AWADDR_I,
    input wire logic [2:0] AWPROT_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    output logic BVALID_O,
    input wire logic BREADY_I,
    output logic [1:0] BRESP_O,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    input wire logic [ADDR_W-1:0] ARADDR_I,
    input wire logic [2:0] ARPROT_I,
    output logic RVALID_O,
    input wire logic RREADY_I,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    input wire logic [PIN_N-1:0] PIN_I,
    input wire logic EXT_PHY_MODE_I,
    input wire logic UNICAST_EV_I,
    input wire logic MAGIC_EV_I,
    input wire logic PATTERN_EV_I,
    input wire logic PERFECT_DA_EV_I,
    input wire logic BROADCAST_EV_I,
    input wire logic GOOD_FRAME_I,
    input wire logic PHY_IRQ_I,
    input wire logic LINK_UP_I,
    input wire logic USB_SUSPEND_I,
    input wire logic USB_RESUME_I,
    output logic REMOTE_WAKE_O,
    output logic SUSPENDED_O,
    output logic PHY_QUIET_O
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [PIN_N-1:0] pin_s1;
        logic [PIN_N-1:0] pin_s2;
        logic [PIN_N-1:0] pin_s3;
        logic [PIN_N-1:0] pin_lvl;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic ext_phy;
        logic [1:0] mode;
        logic frame_wake_en;
        logic energy_detect_wake_en;
        logic [1:0] wake_status_bits;
        logic [FRAME_SRC_N-1:0] frame_src_en;
        logic [3:0] frame_seen;
        logic [PIN_N-1:0] pin_wake_enable;
        logic [PIN_N-1:0] pin_wake_polarity;
        logic link_up_wake_select;
        logic [LOW_PIN_N-1:0] pin_wake_en_n;
        logic [5:0] pin_function_sel;
        logic [2:0] pin_direction;
        logic [PIN_N-1:0] pin_irq_flag;
        dev_state_t state;
        logic remote_wake;
        logic phy_quiet;
    } state_t;

    state_t st_reg;
    state_t st_next;

    logic [PIN_N-1:0] pin_en;
    logic [PIN_N-1:0] pin_act;
    logic [FRAME_SRC_N-1:0] frame_ev;
    logic composite;
    logic all_frame_off;
    logic mac_wake_evt;
    logic frame_req;
    logic good_req;
    logic ed_req;
    logic pin_req;
    logic wake_req;
    logic link_mode;

    assign frame_ev = {BROADCAST_EV_I, PERFECT_DA_EV_I, PATTERN_EV_I, MAGIC_EV_I, UNICAST_EV_I};
    assign link_mode = (st_reg.mode == MODE_A) || (st_reg.mode == MODE_D);

    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++) begin : g_pin
            logic lvl;
            if (gi == 7) begin : g_link
                assign lvl = (st_reg.link_up_wake_select && link_mode) ? LINK_UP_I
                                                                        : st_reg.pin_lvl[gi];
                assign pin_act[gi] = (st_reg.link_up_wake_select && link_mode) ? lvl
                    : (st_reg.pin_wake_polarity[gi] ? lvl : !lvl);
            end else begin : g_plain
                assign lvl = st_reg.pin_lvl[gi];
                assign pin_act[gi] = st_reg.pin_wake_polarity[gi] ? lvl : !lvl;
            end
            if (gi < LOW_PIN_N) begin : g_low
                assign pin_en[gi] = !st_reg.ext_phy && !st_reg.pin_wake_en_n[gi]
                                    && st_reg.pin_wake_enable[gi];
            end else begin : g_high
                assign pin_en[gi] = (st_reg.pin_function_sel[2*(gi-LOW_PIN_N) +: 2] == FUNC_GPIO)
                                    && !st_reg.pin_direction[gi-LOW_PIN_N]
                                    && st_reg.pin_wake_enable[gi];
            end
        end
    endgenerate

    assign composite = |(st_reg.frame_src_en & frame_ev);
    assign all_frame_off = (st_reg.frame_src_en == '0);
    // Good frame with all enables clear.
    assign mac_wake_evt = composite || (all_frame_off && GOOD_FRAME_I);

    assign frame_req = (st_reg.mode == MODE_A) && st_reg.frame_wake_en
                       && !all_frame_off && st_reg.wake_status_bits[1];
    assign good_req = (st_reg.mode == MODE_D) && all_frame_off && st_reg.wake_status_bits[1];
    assign ed_req = (st_reg.mode == MODE_B) && st_reg.energy_detect_wake_en
                    && st_reg.wake_status_bits[0];
    assign pin_req = |(st_reg.pin_irq_flag & pin_en);
    assign wake_req = frame_req || good_req || ed_req || pin_req;

    always_comb begin
        logic aw_take;
        logic w_take;
        logic [ADDR_W-1:0] wa;
        logic [31:0] wd;
        logic [31:0] wm;
        logic [31:0] w1c;
        logic [31:0] nv;
        logic wr_do;
        logic wr_hit;
        logic rd_hit;
        aw_take = 1'b0;
        w_take = 1'b0;
        wa = '0;
        wd = '0;
        wm = '0;
        w1c = '0;
        nv = '0;
        wr_do = 1'b0;
        wr_hit = 1'b0;
        rd_hit = 1'b0;
        st_next = st_reg;

        // Pins cross in from outside; a change counts once stages two and three agree.
        st_next.pin_s1 = PIN_I;
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.pin_s3 = st_reg.pin_s2;
        for (int i = 0; i < PIN_N; i++) begin
            if (st_reg.pin_s2[i] == st_reg.pin_s3[i]) begin
                st_next.pin_lvl[i] = st_reg.pin_s2[i];
            end
        end
        st_next.ext_s1 = EXT_PHY_MODE_I;
        st_next.ext_s2 = st_reg.ext_s1;
        st_next.ext_s3 = st_reg.ext_s2;
        if (st_reg.ext_s2 == st_reg.ext_s3) begin
            st_next.ext_phy = st_reg.ext_s2;
        end

        // Write channel: address and data are taken in either order.
        aw_take = AWVALID_I && st_reg.awready;
        w_take = WVALID_I && st_reg.wready;
        if (aw_take) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = AWADDR_I;
        end
        if (w_take) begin
            st_next.w_held = 1'b1;
            st_next.wdata = WDATA_I;
            st_next.wstrb = WSTRB_I;
        end
        if (st_reg.bvalid && BREADY_I) begin
            st_next.bvalid = 1'b0;
        end
        wr_do = st_next.aw_held && st_next.w_held && !st_reg.bvalid;
        wa = st_next.aw_addr;
        wd = st_next.wdata;
        for (int b = 0; b < 4; b++) begin
            wm[8*b +: 8] = {8{st_next.wstrb[b]}};
        end
        w1c = wd & wm;
        nv = wd;

        // Event flags: a set in the same cycle as a clear always wins.
        // Frame source seen bits.
        if (wr_do && (wa == FRAME_WAKE_ADDR)) begin
            st_next.frame_seen = st_reg.frame_seen & ~w1c[FW_SEEN_LSB +: 4];
        end
        st_next.frame_seen = st_next.frame_seen | (st_reg.frame_src_en[4:1] & frame_ev[4:1]);

        if (wr_do && (wa == PWR_CTL_ADDR)) begin
            st_next.wake_status_bits = st_reg.wake_status_bits & ~w1c[PWR_STATUS_LSB +: 2];
        end
        // Hold bit 1 while MAC event persists.
        if (mac_wake_evt) begin
            st_next.wake_status_bits[1] = 1'b1;
        end
        // Hold bit 0 while PHY interrupt persists.
        if (PHY_IRQ_I) begin
            st_next.wake_status_bits[0] = 1'b1;
        end

        if (wr_do && (wa == IRQ_STATUS_ADDR)) begin
            st_next.pin_irq_flag = st_reg.pin_irq_flag & ~w1c[PIN_N-1:0];
        end
        st_next.pin_irq_flag = st_next.pin_irq_flag | (pin_en & pin_act);

        if (wr_do) begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            wr_hit = 1'b1;
            case (wa)
                PWR_CTL_ADDR: begin
                    if (wm[0]) begin
                        st_next.mode = nv[PWR_MODE_LSB +: 2];
                        st_next.frame_wake_en = nv[PWR_FRAME_EN_BIT];
                        st_next.energy_detect_wake_en = nv[PWR_ENERGY_DETECT_WAKE_EN_BIT];
                    end
                end
                FRAME_WAKE_ADDR: begin
                    if (wm[0]) begin
                        st_next.frame_src_en = nv[FW_EN_LSB +: FRAME_SRC_N];
                    end
                end
                PIN_WAKE_ADDR: begin
                    st_next.pin_wake_enable = (nv[PIN_N-1:0] & wm[PIN_N-1:0])
                                              | (st_reg.pin_wake_enable & ~wm[PIN_N-1:0]);
                    st_next.pin_wake_polarity =
                        (nv[PW_POL_LSB +: PIN_N] & wm[PW_POL_LSB +: PIN_N])
                        | (st_reg.pin_wake_polarity & ~wm[PW_POL_LSB +: PIN_N]);
                    if (wm[PW_LINK_SEL_BIT]) begin
                        st_next.link_up_wake_select = nv[PW_LINK_SEL_BIT];
                    end
                end
                PIN_CFG_ADDR: begin
                    if (wm[0]) begin
                        st_next.pin_wake_en_n = nv[LOW_PIN_N-1:0];
                    end
                end
                LED_PIN_CFG_ADDR: begin
                    if (wm[0]) begin
                        st_next.pin_function_sel = nv[LED_FUNC_LSB +: 6];
                    end
                    if (wm[LED_DIR_LSB]) begin
                        st_next.pin_direction = nv[LED_DIR_LSB +: 3];
                    end
                end
                IRQ_STATUS_ADDR: begin
                    wr_hit = 1'b1;
                end
                default: begin
                    wr_hit = 1'b0;
                end
            endcase
            st_next.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        st_next.awready = !st_next.aw_held && !st_next.bvalid;
        st_next.wready = !st_next.w_held && !st_next.bvalid;

        // Read channel: answer one cycle after the address is taken.
        if (st_reg.rvalid && RREADY_I) begin
            st_next.rvalid = 1'b0;
        end
        if (ARVALID_I && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = '0;
            rd_hit = 1'b1;
            case (ARADDR_I)
                PWR_CTL_ADDR: begin
                    st_next.rdata[PWR_MODE_LSB +: 2] = st_reg.mode;
                    st_next.rdata[PWR_FRAME_EN_BIT] = st_reg.frame_wake_en;
                    st_next.rdata[PWR_ENERGY_DETECT_WAKE_EN_BIT] = st_reg.energy_detect_wake_en;
                    st_next.rdata[PWR_STATUS_LSB +: 2] = st_reg.wake_status_bits;
                    st_next.rdata[PWR_SUSPENDED_BIT] = (st_reg.state == ST_SUSPEND);
                    st_next.rdata[PWR_EXT_PHY_BIT] = st_reg.ext_phy;
                end
                FRAME_WAKE_ADDR: begin
                    st_next.rdata[FW_EN_LSB +: FRAME_SRC_N] = st_reg.frame_src_en;
                    st_next.rdata[FW_SEEN_LSB +: 4] = st_reg.frame_seen;
                end
                PIN_WAKE_ADDR: begin
                    st_next.rdata[PIN_N-1:0] = st_reg.pin_wake_enable;
                    st_next.rdata[PW_POL_LSB +: PIN_N] = st_reg.pin_wake_polarity;
                    st_next.rdata[PW_LINK_SEL_BIT] = st_reg.link_up_wake_select;
                end
                PIN_CFG_ADDR: begin
                    st_next.rdata[LOW_PIN_N-1:0] = st_reg.pin_wake_en_n;
                end
                LED_PIN_CFG_ADDR: begin
                    st_next.rdata[LED_FUNC_LSB +: 6] = st_reg.pin_function_sel;
                    st_next.rdata[LED_DIR_LSB +: 3] = st_reg.pin_direction;
                end
                IRQ_STATUS_ADDR: begin
                    st_next.rdata[PIN_N-1:0] = st_reg.pin_irq_flag;
                end
                default: begin
                    rd_hit = 1'b0;
                end
            endcase
            st_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        st_next.arready = !st_next.rvalid;

        // Suspend sequencing; a pending request wakes at once, so status must be clear first.
        st_next.remote_wake = 1'b0;
        case (st_reg.state)
            ST_NORMAL: begin
                if (USB_SUSPEND_I) begin
                    st_next.state = ST_SUSPEND;
                end
            end
            ST_SUSPEND: begin
                if (USB_RESUME_I) begin
                    st_next.state = ST_NORMAL;
                end else if (wake_req) begin
                    st_next.state = ST_NORMAL;
                    st_next.remote_wake = 1'b1;
                end
            end
            default: begin
                st_next.state = ST_NORMAL;
            end
        endcase
        // PHY kept quiet in energy detect suspend.
        st_next.phy_quiet = (st_next.state == ST_SUSPEND) && (st_reg.mode == MODE_B)
                            && st_reg.energy_detect_wake_en;
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            st_reg <= '0;
            st_reg.mode <= MODE_DEFAULT;
            st_reg.pin_wake_en_n <= PIN_EN_N_RESET;
            st_reg.state <= ST_NORMAL;
            st_reg.awready <= 1'b1;
            st_reg.wready <= 1'b1;
            st_reg.arready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign AWREADY_O = st_reg.awready;
    assign WREADY_O = st_reg.wready;
    assign BVALID_O = st_reg.bvalid;
    assign BRESP_O = st_reg.bresp;
    assign ARREADY_O = st_reg.arready;
    assign RVALID_O = st_reg.rvalid;
    assign RDATA_O = st_reg.rdata;
    assign RRESP_O = st_reg.rresp;
    assign REMOTE_WAKE_O = st_reg.remote_wake;
    assign SUSPENDED_O = (st_reg.state == ST_SUSPEND);
    assign PHY_QUIET_O = st_reg.phy_quiet;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_B_I);

    AST_EXT_PHY_LOW_PINS: assert property (st_reg.ext_phy |-> (pin_en[LOW_PIN_N-1:0] == '0))
        else $error("Low pin wake enabled in external PHY mode.");
    AST_HIGH_PIN_FLAG: assert property ((pin_en[9] && pin_act[9]) |=> st_reg.pin_irq_flag[9])
        else $error("Pin 9 wake flag not set.");
    AST_LOW_PIN_DISABLED: assert property (st_reg.pin_wake_en_n[3] |-> !pin_en[3])
        else $error("Pin 3 enabled with its disable bit set.");
    AST_MAGIC_SEEN: assert property ((MAGIC_EV_I && st_reg.frame_src_en[1]) |=> st_reg.frame_seen[0])
        else $error("Magic frame seen bit not set.");
    AST_FRAME_CODE: assert property (frame_req |-> (st_reg.mode == MODE_A))
        else $error("Frame wake outside code 00b.");
    AST_ENERGY_CODE: assert property (ed_req |-> (st_reg.mode == MODE_B))
        else $error("Energy wake outside code 01b.");
    AST_GOOD_CODE: assert property (good_req |-> (st_reg.mode == MODE_D && all_frame_off))
        else $error("Good frame wake outside code 11b.");
    AST_WAKE_PULSE: assert property ((SUSPENDED_O && wake_req && !USB_RESUME_I)
        |=> (REMOTE_WAKE_O && !SUSPENDED_O) ##1 !REMOTE_WAKE_O)
        else $error("Remote wake not pulsed on wake request.");
    AST_STATUS1_HOLD: assert property (mac_wake_evt |=> st_reg.wake_status_bits[1][*2] or
        (st_reg.wake_status_bits[1] ##1 1'b1))
        else $error("Status bit 1 cleared while MAC event present.");
    AST_STATUS0_HOLD: assert property (PHY_IRQ_I |=> st_reg.wake_status_bits[0])
        else $error("Status bit 0 cleared while PHY interrupt present.");
    AST_LINK_PIN7: assert property ((st_reg.link_up_wake_select && link_mode && LINK_UP_I
        && pin_en[7]) |=> st_reg.pin_irq_flag[7])
        else $error("Link up did not flag pin 7.");

    COV_PIN_WAKE: cover property (SUSPENDED_O && pin_req ##1 REMOTE_WAKE_O);
    COV_FRAME_WAKE: cover property (SUSPENDED_O && frame_req ##1 REMOTE_WAKE_O);
    COV_ENERGY_WAKE: cover property (SUSPENDED_O && ed_req ##1 REMOTE_WAKE_O);
    COV_GOOD_WAKE: cover property (SUSPENDED_O && good_req ##1 REMOTE_WAKE_O);

endmodule

`default_nettype wire

// ### wake_pkg.sv
// Constants and types shared by the suspend wake event logic.
package wake_pkg;

    localparam int ADDR_W = 8;
    localparam int PIN_N = 11;
    localparam int LOW_PIN_N = 8;
    localparam int FRAME_SRC_N = 5;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] PWR_CTL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] FRAME_WAKE_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] PIN_WAKE_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] PIN_CFG_ADDR = 8'h0C;
    localparam logic [ADDR_W-1:0] LED_PIN_CFG_ADDR = 8'h10;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 8'h14;

    // Power management control field positions.
    localparam int PWR_MODE_LSB = 0;
    localparam int PWR_FRAME_EN_BIT = 2;
    localparam int PWR_ENERGY_DETECT_WAKE_EN_BIT = 3;
    localparam int PWR_STATUS_LSB = 4;
    localparam int PWR_SUSPENDED_BIT = 6;
    localparam int PWR_EXT_PHY_BIT = 7;

    // Frame wake control field positions.
    localparam int FW_EN_LSB = 0;
    localparam int FW_SEEN_LSB = 8;

    // Pin wake field positions.
    localparam int PW_POL_LSB = 16;
    localparam int PW_LINK_SEL_BIT = 31;

    // LED pin configuration field positions.
    localparam int LED_FUNC_LSB = 0;
    localparam int LED_DIR_LSB = 8;

    // Suspend mode codes.
    localparam logic [1:0] MODE_A = 2'h0;
    localparam logic [1:0] MODE_B = 2'h1;
    localparam logic [1:0] MODE_C = 2'h2;
    localparam logic [1:0] MODE_D = 2'h3;
    localparam logic [1:0] MODE_DEFAULT = MODE_C;

    localparam logic [1:0] FUNC_GPIO = 2'h0;
    localparam logic [7:0] PIN_EN_N_RESET = 8'hFF;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'b01,
        ST_SUSPEND = 2'b10
    } dev_state_t;

endpackage
